// File: verilog/telemetry_pkg.sv
// Shared constants and helpers for the supply telemetry I2C link
package telemetry_pkg;
    // Converter bus addresses and highest used channel of each
    localparam logic [6:0] CONV1_ADDR = 7'h49;
    localparam logic [6:0] CONV2_ADDR = 7'h4a;
    localparam logic [2:0] CONV1_LAST_CH = 3'h5;
    localparam logic [2:0] CONV2_LAST_CH = 3'h6;
    // Command byte layout
    localparam int SD_BIT = 7;
    localparam int CSEL_LSB = 4;
    localparam int REF_PWR_BIT = 3;
    localparam int CONV_PWR_BIT = 2;
    // Timing
    localparam int PCLK_HZ = 40_000_000;
    localparam int I2C_HZ = 10_000;
    localparam int QUARTER_CYCLES = (PCLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
    localparam int REFRESH_S = 15;
    localparam int REFRESH_CYCLES = REFRESH_S * PCLK_HZ;
    // Register map of the poller
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] RESULT_OFS = 12'h040;
    localparam logic [11:0] RESULT_END = 12'h07c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_KICK_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PRES_LSB = 1;
    localparam int ST_NACK_BIT = 3;
    localparam logic ENABLE_RST = 1'h0;
    localparam logic [1:0] PRESENT_RST = 2'h0;

    function automatic logic [7:0] make_cmd(input logic [2:0] ch);
        logic [7:0] c;
        c = 8'h00;
        c[SD_BIT] = 1'b1;
        c[CSEL_LSB +: 3] = {ch[0], ch[2:1]};
        c[REF_PWR_BIT] = 1'b1;
        c[CONV_PWR_BIT] = 1'b1;
        return c;
    endfunction : make_cmd

    function automatic logic [2:0] cmd_channel(input logic [7:0] c);
        return {c[CSEL_LSB +: 2], c[CSEL_LSB + 2]};
    endfunction : cmd_channel

    function automatic logic [6:0] dev_addr(input logic dev);
        return dev ? CONV2_ADDR : CONV1_ADDR;
    endfunction : dev_addr
endpackage : telemetry_pkg

// File: verilog/i2c_link_if.sv
// Open-drain two-wire link between the poller and the converters
interface i2c_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Pull-up wins unless an enabled driver pulls low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

    modport master (
        output scl_o,
        output scl_oe,
        output sda_m_o,
        output sda_m_oe,
        input scl,
        input sda
    );
    modport slave (
        output sda_s_o,
        output sda_s_oe,
        input scl,
        input sda
    );
endinterface : i2c_link_if

// File: verilog/power_supply_converters.sv
// Pair of 8-channel converters answering on the telemetry link
module power_supply_converters
    import telemetry_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_rst_n,
    i2c_link_if.slave link,
    input wire logic conv1_present,
    input wire logic conv2_present,
    input wire logic [7:0][11:0] minus_side_data,
    input wire logic [7:0][11:0] plus_side_data
);
    typedef enum {L_IDLE, L_ADDR, L_ACK, L_RX, L_TX, L_TXACK} slv_state_t;

    slv_state_t st_reg;
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic rw_reg, sel_reg, mack_reg, lsb_reg, sda_low_reg;
    logic [2:0] ch_reg [2];
    logic single_reg [2];
    logic [11:0] word_reg;
    logic scl_rise, scl_fall, start_seen, stop_seen, hit1, hit2;

    // Samples on the link are only answered, never initiated
    assign link.sda_s_o = 1'b0; // [RULE1]
    assign link.sda_s_oe = sda_low_reg;

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= link.scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
    assign hit1 = conv1_present && sh_reg[7:1] == CONV1_ADDR; // [RULE11]
    assign hit2 = conv2_present && sh_reg[7:1] == CONV2_ADDR; // [RULE12]

    // Raw counts against the internal reference; unused channels read 0
    function automatic logic [11:0] pick(input logic dev, // [RULE15]
                                         input logic [2:0] ch,
                                         input logic single);
        if (!single)
            return 12'h000;
        if (!dev) // [RULE13] [RULE14]
            return (ch <= CONV1_LAST_CH) ? minus_side_data[ch] : 12'h000;
        return (ch <= CONV2_LAST_CH) ? plus_side_data[ch] : 12'h000;
    endfunction : pick

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_reg <= L_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            rw_reg <= 1'b0;
            sel_reg <= 1'b0;
            mack_reg <= 1'b0;
            lsb_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            word_reg <= 12'h000;
            ch_reg[0] <= 3'h0;
            ch_reg[1] <= 3'h0;
            single_reg[0] <= 1'b0;
            single_reg[1] <= 1'b0;
        end else if (start_seen) begin
            st_reg <= L_ADDR;
            cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
        end else if (stop_seen) begin
            st_reg <= L_IDLE;
            sda_low_reg <= 1'b0;
        end else begin
            case (st_reg)
                L_ADDR: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s2};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        if (hit1 || hit2) begin
                            sel_reg <= hit2;
                            rw_reg <= sh_reg[0];
                            sda_low_reg <= 1'b1;
                            st_reg <= L_ACK;
                            // Value of the addressed device's own channel
                            word_reg <= pick(hit2, ch_reg[hit2], // [RULE3]
                                             single_reg[hit2]);
                        end else begin
                            st_reg <= L_IDLE;
                        end
                    end
                end
                L_ACK: begin
                    if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            // High byte first, top nibble zero
                            sh_reg <= {4'h0, word_reg[11:8]}; // [RULE17]
                            sda_low_reg <= 1'b1;
                            lsb_reg <= 1'b0;
                            st_reg <= L_TX;
                        end else begin
                            sda_low_reg <= 1'b0;
                            st_reg <= L_RX;
                        end
                    end
                end
                L_RX: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s2};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        ch_reg[sel_reg] <= cmd_channel(sh_reg); // [RULE3]
                        single_reg[sel_reg] <= sh_reg[SD_BIT];
                        sda_low_reg <= 1'b1;
                        st_reg <= L_ACK;
                    end
                end
                L_TX: begin
                    if (scl_fall) begin
                        if (cnt_reg == 4'h7) begin
                            sda_low_reg <= 1'b0;
                            st_reg <= L_TXACK;
                        end else begin
                            sda_low_reg <= !sh_reg[6];
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                L_TXACK: begin
                    if (scl_rise) begin
                        mack_reg <= !sda_s2;
                    end else if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        if (mack_reg) begin
                            // Low byte, then the pair repeats
                            sh_reg <= lsb_reg ? {4'h0, word_reg[11:8]}
                                              : word_reg[7:0]; // [RULE17]
                            sda_low_reg <= lsb_reg ? 1'b1 : !word_reg[7];
                            lsb_reg <= !lsb_reg;
                            st_reg <= L_TX;
                        end else begin
                            st_reg <= L_IDLE;
                        end
                    end
                end
                default: begin
                    sda_low_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule : power_supply_converters

// File: verilog/housekeeping_poller.sv
// Housekeeping side: polls the supply converters and holds the results
// Summary of operation
// [RULE1] Poller is sole master; converters only answer
// [RULE2] Each transfer names one converter and channel; probe and read transfers here send only the address byte
// [RULE3] Converter returns the selected converter's channel
// [RULE4] Probe each converter's address acknowledge separately
// [RULE5] Never poll a converter that failed probing
// [RULE6] Every channel refreshed within fifteen seconds
// [RULE7] Command byte keeps converter power bit set
// [RULE8] Command byte keeps reference power bit set
// [RULE9] Commands always select single-ended inputs
// [RULE10] Bus clock runs at ten kilohertz
// [RULE11] First converter answers address 0x49
// [RULE12] Second converter answers address 0x4A
// [RULE13] First converter: voltages 0-2, temperatures 3-5
// [RULE14] Second: voltages 0-2, temperatures 3-5, board 6
// [RULE15] Results are counts of the internal reference
// [RULE16] Channels polled in ascending order
// [RULE17] Result is two bytes, high first, 12 bits
module housekeeping_poller
    import telemetry_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYCLES,
    parameter int REFRESH = REFRESH_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    i2c_link_if.master link
);
    typedef enum {S_IDLE, S_START, S_BITS, S_STOP} bus_state_t;
    typedef enum {J_PROBE, J_CMD, J_READ} job_t;

    bus_state_t st_reg;
    job_t job_reg, job_next;
    logic [15:0] qcnt_reg;
    logic [31:0] ref_reg;
    logic [1:0] phase_reg, byte_reg, last_byte;
    logic [3:0] bit_reg;
    logic [7:0] txsh_reg, rxsh_reg;
    logic [3:0] msb_reg;
    logic dev_reg, dev_next, done_next, ack_ok_reg, fail_reg;
    logic [2:0] chan_reg, chan_next, last_ch;
    logic [1:0] present_reg;
    logic enable_reg, kick_reg, nack_reg;
    logic scl_low_reg, sda_low_reg, sda_s1, sda_s2;
    logic [11:0] result_reg [16];
    logic tick, scan_go, writing, wr_en, byte_end, nack_now;
    logic [31:0] rd_word, prdata_reg;
    logic addr_hit;

    // Only this end ever pulls the clock line
    assign link.scl_o = 1'b0; // [RULE1]
    assign link.sda_m_o = 1'b0;
    assign link.scl_oe = scl_low_reg;
    assign link.sda_m_oe = sda_low_reg;

    // Four quarters per bit period give the bus rate
    assign tick = qcnt_reg == 16'(QUARTER - 1); // [RULE10]
    assign scan_go = st_reg == S_IDLE
                     && (kick_reg || (enable_reg && ref_reg == 32'h0000_0000));
    assign writing = job_reg != J_READ || byte_reg == 2'h0;
    assign last_byte = job_reg == J_PROBE ? 2'h0
                       : (job_reg == J_CMD ? 2'h1 : 2'h2);
    assign last_ch = dev_reg ? CONV2_LAST_CH : CONV1_LAST_CH;
    assign byte_end = st_reg == S_BITS && tick && phase_reg == 2'h3
                      && bit_reg == 4'h8;
    assign nack_now = writing && !ack_ok_reg;

    // Byte to shift out: address with direction, or channel command
    function automatic logic [7:0] tx_byte(input job_t j, input logic d,
                                           input logic [2:0] c,
                                           input logic [1:0] b);
        if (b == 2'h0)
            return {dev_addr(d), j == J_READ}; // [RULE2]
        return make_cmd(c); // [RULE7] [RULE8] [RULE9]
    endfunction : tx_byte

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            qcnt_reg <= 16'h0000;
        else if (st_reg == S_IDLE || tick)
            qcnt_reg <= 16'h0000;
        else
            qcnt_reg <= qcnt_reg + 16'h0001;
    end

    // Restart period bounds the age of every stored value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ref_reg <= 32'h0000_0000;
        else if (!enable_reg || scan_go)
            ref_reg <= scan_go ? 32'(REFRESH - 1) : 32'h0000_0000; // [RULE6]
        else if (ref_reg != 32'h0000_0000)
            ref_reg <= ref_reg - 32'h0000_0001;
    end

    // Job that follows the one just closed by a stop
    always_comb begin
        job_next = J_CMD;
        dev_next = dev_reg;
        chan_next = chan_reg;
        done_next = 1'b0;
        if (job_reg == J_PROBE) begin
            if (!dev_reg) begin
                job_next = J_PROBE; // [RULE4]
                dev_next = 1'b1;
            end else if (present_reg != 2'h0) begin
                dev_next = !present_reg[0]; // [RULE5]
                chan_next = 3'h0;
            end else begin
                done_next = 1'b1;
            end
        end else if (job_reg == J_CMD && !fail_reg) begin
            job_next = J_READ;
        end else if (chan_reg != last_ch) begin
            chan_next = chan_reg + 3'h1; // [RULE16]
        end else if (!dev_reg && present_reg[1]) begin
            dev_next = 1'b1; // [RULE5]
            chan_next = 3'h0;
        end else begin
            done_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= S_IDLE;
            job_reg <= J_PROBE;
            dev_reg <= 1'b0;
            chan_reg <= 3'h0;
            phase_reg <= 2'h0;
            byte_reg <= 2'h0;
            bit_reg <= 4'h0;
            txsh_reg <= 8'h00;
            rxsh_reg <= 8'h00;
            ack_ok_reg <= 1'b0;
            fail_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end else if (scan_go) begin
            st_reg <= S_START;
            job_reg <= J_PROBE; // [RULE4]
            dev_reg <= 1'b0;
            chan_reg <= 3'h0;
            phase_reg <= 2'h0;
        end else if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (st_reg)
                S_START: begin
                    scl_low_reg <= phase_reg == 2'h2 || phase_reg == 2'h3;
                    sda_low_reg <= phase_reg != 2'h0;
                    if (phase_reg == 2'h3) begin
                        st_reg <= S_BITS;
                        bit_reg <= 4'h0;
                        byte_reg <= 2'h0;
                        fail_reg <= 1'b0;
                        txsh_reg <= tx_byte(job_reg, dev_reg, chan_reg, 2'h0);
                    end
                end
                S_BITS: begin
                    if (phase_reg == 2'h0) begin
                        if (bit_reg == 4'h8)
                            sda_low_reg <= !writing && byte_reg != last_byte;
                        else
                            sda_low_reg <= writing && !txsh_reg[7];
                    end else if (phase_reg == 2'h1) begin
                        scl_low_reg <= 1'b0;
                    end else if (phase_reg == 2'h2) begin
                        if (bit_reg == 4'h8)
                            ack_ok_reg <= !sda_s2;
                        else
                            rxsh_reg <= {rxsh_reg[6:0], sda_s2};
                    end else begin
                        scl_low_reg <= 1'b1;
                        if (bit_reg != 4'h8) begin
                            bit_reg <= bit_reg + 4'h1;
                            txsh_reg <= {txsh_reg[6:0], 1'b0};
                        end else if (nack_now || byte_reg == last_byte) begin
                            fail_reg <= nack_now;
                            st_reg <= S_STOP;
                        end else begin
                            bit_reg <= 4'h0;
                            byte_reg <= byte_reg + 2'h1;
                            txsh_reg <= tx_byte(job_reg, dev_reg, chan_reg,
                                                byte_reg + 2'h1);
                        end
                    end
                end
                S_STOP: begin
                    scl_low_reg <= phase_reg == 2'h0;
                    sda_low_reg <= phase_reg != 2'h2 && phase_reg != 2'h3;
                    if (phase_reg == 2'h3) begin
                        st_reg <= done_next ? S_IDLE : S_START;
                        job_reg <= job_next;
                        dev_reg <= dev_next;
                        chan_reg <= chan_next;
                    end
                end
                default: begin
                    scl_low_reg <= 1'b0;
                    sda_low_reg <= 1'b0;
                end
            endcase
        end
    end

    // Presence flags and stored readings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            present_reg <= PRESENT_RST;
            msb_reg <= 4'h0;
            for (int i = 0; i < 16; i++)
                result_reg[i] <= 12'h000;
        end else if (byte_end) begin
            if (job_reg == J_PROBE)
                present_reg[dev_reg] <= ack_ok_reg; // [RULE4]
            else if (job_reg == J_READ && byte_reg == 2'h1)
                msb_reg <= rxsh_reg[3:0]; // [RULE17]
            else if (job_reg == J_READ && byte_reg == 2'h2)
                result_reg[{dev_reg, chan_reg}] <= {msb_reg, rxsh_reg};
        end
    end

    assign wr_en = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= ENABLE_RST;
            kick_reg <= 1'b0;
        end else begin
            if (wr_en && paddr == CTRL_OFS)
                enable_reg <= pwdata[CTRL_EN_BIT];
            // A request that lands with the scan start is kept
            if (wr_en && paddr == CTRL_OFS && pwdata[CTRL_KICK_BIT])
                kick_reg <= 1'b1;
            else if (scan_go)
                kick_reg <= 1'b0;
        end
    end

    // Sticky: any refusal in a command or read transfer, cleared by writing one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            nack_reg <= 1'b0;
        else if (byte_end && nack_now && job_reg != J_PROBE)
            nack_reg <= 1'b1;
        else if (wr_en && paddr == STATUS_OFS && pwdata[ST_NACK_BIT])
            nack_reg <= 1'b0;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        addr_hit = 1'b1;
        if (paddr == CTRL_OFS) begin
            rd_word[CTRL_EN_BIT] = enable_reg;
        end else if (paddr == STATUS_OFS) begin
            rd_word[ST_BUSY_BIT] = st_reg != S_IDLE;
            rd_word[ST_PRES_LSB +: 2] = present_reg;
            rd_word[ST_NACK_BIT] = nack_reg;
        end else if (paddr >= RESULT_OFS && paddr <= RESULT_END
                     && paddr[1:0] == 2'h0) begin
            rd_word[11:0] = result_reg[paddr[5:2]];
        end else begin
            addr_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable)
            prdata_reg <= rd_word;
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
endmodule : housekeeping_poller

// File: test/link_properties.sv
// Timing and ownership checks on the telemetry link wires
module link_properties #(
    parameter int QUARTER = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HI_MIN = 2 * QUARTER - 1;
    localparam int LO_MAX = 3 * QUARTER + 1;
    localparam int QW = QUARTER + 2;
    logic [31:0] hi_cnt;
    logic [31:0] lo_cnt;
    // Counted on the drive, not the wire, so the sync lag stays out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt <= '0;
        else if (scl_oe) hi_cnt <= '0;
        else hi_cnt <= hi_cnt + 32'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lo_cnt <= '0;
        else if (!scl_oe) lo_cnt <= '0;
        else lo_cnt <= lo_cnt + 32'h1;
    end

    sequence start_seen;
        scl && $rose(sda_m_oe);
    endsequence
    sequence stop_seen;
        scl && $fell(sda_m_oe);
    endsequence

    a_scl_high_time: assert property (@(posedge pclk)
        disable iff (!presetn) $rose(scl_oe) |-> hi_cnt >= HI_MIN)
        else $error("clock high phase too short");
    a_scl_low_time: assert property (@(posedge pclk)
        disable iff (!presetn) lo_cnt <= LO_MAX)
        else $error("clock held low too long");
    a_start_bus_free: assert property (@(posedge pclk)
        disable iff (!presetn) start_seen |-> !sda_s_oe)
        else $error("converter holds data at a start");
    a_start_by_master: assert property (@(posedge pclk)
        disable iff (!presetn) $fell(sda) && $past(scl) && scl |-> sda_m_oe)
        else $error("start not made by the poller");
    a_start_then_low: assert property (@(posedge pclk)
        disable iff (!presetn) start_seen |-> ##[1:QW] scl_oe)
        else $error("start not followed by clock low");
    a_stop_then_idle: assert property (@(posedge pclk)
        disable iff (!presetn) stop_seen |=> !scl_oe [*8])
        else $error("clock pulled right after stop");
    a_no_clash_high: assert property (@(posedge pclk)
        disable iff (!presetn) scl && $past(scl) |-> !(sda_m_oe && sda_s_oe))
        else $error("both ends drive data while clock high");
    a_slave_moves_low: assert property (@(posedge link_clk)
        disable iff (!link_rst_n) $changed(sda_s_oe) |-> !scl)
        else $error("converter moved data while clock high");
endmodule : link_properties

// File: test/testbench.sv
// Bench joining the poller and the converters on one link
module testbench
    import telemetry_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QUARTER = 5;
    localparam int REFRESH = 20000;
    logic pclk = 0, link_clk = 0, presetn = 0, link_rst_n = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic conv1_present = 1, conv2_present = 1, scl_w, sda_w;
    logic [7:0][11:0] minus_side_data = '0, plus_side_data = '0;
    logic [7:0] sh, ad;
    int num_errors = 0, n_checks = 0, cyc = 0, ci = 0, bi = 0, fb = 0;

    i2c_link_if i2c_link_if_inst ();
    assign scl_w = i2c_link_if_inst.scl;
    assign sda_w = i2c_link_if_inst.sda;
    housekeeping_poller #(.QUARTER(QUARTER), .REFRESH(REFRESH))
        housekeeping_poller_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(i2c_link_if_inst.master));
    power_supply_converters power_supply_converters_inst (
        .link_clk(link_clk), .link_rst_n(link_rst_n),
        .link(i2c_link_if_inst.slave), .conv1_present(conv1_present),
        .conv2_present(conv2_present), .minus_side_data(minus_side_data),
        .plus_side_data(plus_side_data));
    link_properties #(.QUARTER(QUARTER)) link_properties_inst (
        .pclk(pclk), .presetn(presetn), .link_clk(link_clk),
        .link_rst_n(link_rst_n), .scl_oe(i2c_link_if_inst.scl_oe),
        .sda_m_oe(i2c_link_if_inst.sda_m_oe),
        .sda_s_oe(i2c_link_if_inst.sda_s_oe), .scl(scl_w), .sda(sda_w));

    initial forever #12.5 pclk = ~pclk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task finish_test;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Busy lags the kick by a cycle or two
    task kick(input int start);
        ci = start;
        apb(1'b1, CTRL_OFS, 32'h2);
        repeat (8) @(posedge pclk);
        r = 32'h1;
        while (r[ST_BUSY_BIT] !== 1'b0) apb(1'b0, STATUS_OFS, '0);
    endtask : kick

    task chk_dev(input int dev, input int last, input logic [7:0][11:0] d);
        for (int c = 0; c < 8; c++) begin
            apb(1'b0, RESULT_OFS + 12'(32 * dev + 4 * c), '0);
            chk(r, c <= last ? 32'(d[c]) : 32'h0);
        end
    endtask : chk_dev

    function automatic logic [31:0] exp_cmd(input int i);
        int k;
        k = i % 13;
        return 32'(k < 6 ? {CONV1_ADDR, 3'(k)} : {CONV2_ADDR, 3'(k - 6)});
    endfunction : exp_cmd

    // Wire monitor: decodes every command byte the poller sends
    always @(negedge sda_w) if (scl_w === 1'b1) begin
        bi = 0;
        fb = 0;
    end
    always @(posedge scl_w) begin
        if (bi < 8) begin
            sh = {sh[6:0], sda_w};
            bi++;
        end else begin
            bi = 0;
            if (fb == 0) ad = sh;
            else if (fb == 1 && ad[0] === 1'b0) begin
                chk(32'({ad[7:1], sh[5:4], sh[6]}), exp_cmd(ci));
                chk(32'({sh[7], sh[3:0]}), 32'h1c);
                ci++;
            end
            fb++;
        end
    end

    task t_reset;
        apb(1'b0, CTRL_OFS, '0);
        chk(r, 32'(ENABLE_RST)); // reset value
        apb(1'b0, STATUS_OFS, '0);
        chk(32'(r[3:1]), 32'(PRESENT_RST)); // reset value
        apb(1'b0, 12'h100, '0);
        chk(r, 32'h0); // refused read
        chk(32'(e), 32'h1); // refused read
        apb(1'b1, 12'h002, 32'h1);
        chk(32'(e), 32'h1); // refused write
    endtask : t_reset

    task t_both;
        for (int i = 0; i < 8; i++) begin
            minus_side_data[i] <= 12'h0a5 + 12'(i) * 12'h111;
            plus_side_data[i] <= 12'hfff - 12'(i) * 12'h123;
        end
        kick(0);
        chk(32'(r[3:1]), 32'h3);
        chk(32'(ci), 32'hd);
        chk_dev(0, 5, minus_side_data);
        chk_dev(1, 6, plus_side_data);
    endtask : t_both

    task t_absent;
        conv1_present <= 1'b0;
        for (int i = 0; i < 8; i++) plus_side_data[i] <= 12'h800 + 12'(i);
        kick(6);
        chk(32'(r[3:1]), 32'h2);
        chk(32'(ci), 32'hd);
        chk_dev(1, 6, plus_side_data);
    endtask : t_absent

    task t_periodic;
        conv1_present <= 1'b1;
        ci = 0;
        apb(1'b1, CTRL_OFS, 32'h1);
        for (int k = 0; k < REFRESH + 13000 && ci < 26; k++) @(posedge pclk);
        chk(32'(ci >= 26), 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
    endtask : t_periodic

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            finish_test;
        end
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        link_rst_n <= 1'b1;
        t_reset;
        t_both;
        t_absent;
        t_periodic;
        finish_test;
    end
endmodule : testbench
